// ### dmx_map_page.sv
// Request routing and extended page address part of the bus DMA controller.
// Assumes the transfer engine supplies channel acknowledges, low address
// bits and 16-Mbyte crossing pulses on the same clock as this block.
`default_nettype none
module dmx_map_page (
   input wire logic clk,
   input wire logic rst,
   input wire logic [11:0] reg_addr,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata,
   input wire logic extended_mode_enable,
   input wire logic ext_req_in_0,
   input wire logic ext_req_in_1,
   output logic ext_ack_out_0,
   output logic ext_ack_out_1,
   input wire logic serial_tx1_request,
   input wire logic serial_tx2_request,
   input wire logic serial_rx1_request,
   input wire logic serial_rx2_request,
   output logic serial_tx1_ack,
   output logic serial_tx2_ack,
   output logic serial_rx1_ack,
   output logic serial_rx2_ack,
   output logic [dmx_pkg::DMX_CHANNELS-1:0] chan_req,
   input wire logic [dmx_pkg::DMX_CHANNELS-1:0] chan_ack,
   input wire logic ch3_page_up,
   input wire logic ch3_page_down,
   input wire logic ch5_page_up,
   input wire logic ch5_page_down,
   input wire logic [dmx_pkg::DMX_PAGE_CHANNELS-1:0]
      [dmx_pkg::DMX_LOW_ADDR_W-1:0] low_addr,
   output logic [dmx_pkg::DMX_PAGE_CHANNELS-1:0]
      [dmx_pkg::DMX_ADDR_W-1:0] mem_addr,
   output logic [3:0] ch0_addr_top_bits,
   output logic [3:0] ch1_addr_top_bits,
   output logic [3:0] ch2_addr_top_bits,
   output logic [3:0] ch3_addr_top_bits,
   output logic [3:0] ch5_addr_top_bits
);
   import dmx_pkg::*;

   logic [15:0] ext_map_q;
   logic [15:0] ser_map_q;
   logic [7:0] rdata_q;
   logic [7:0] rdata_d;
   logic [DMX_SYNC_STAGES-1:0] req0_sync_q;
   logic [DMX_SYNC_STAGES-1:0] req1_sync_q;
   logic [DMX_PAGE_CHANNELS-1:0][DMX_ADDR_W-1:0] mem_addr_q;
   logic [DMX_PAGE_CHANNELS-1:0][DMX_PAGE_W-1:0] page_q;
   logic [DMX_PAGE_CHANNELS-1:0] page_wr;
   logic [DMX_PAGE_CHANNELS-1:0] page_up;
   logic [DMX_PAGE_CHANNELS-1:0] page_down;
   logic [5:0][3:0] src_sel;
   logic [5:0] src_ok;
   logic [5:0] src_req;
   logic [5:0] src_ack;
   logic [2:0] src_chan [6];
   logic sel_ext_lo;
   logic sel_ext_hi;
   logic sel_ser_lo;
   logic sel_ser_hi;

   // Selector fields: 0 and 1 external pairs, then rx1, rx2, tx1, tx2.
   assign src_sel[0] = ext_map_q[DMX_PAIR0_LSB +: DMX_SEL_W];
   assign src_sel[1] = ext_map_q[DMX_PAIR1_LSB +: DMX_SEL_W];
   assign src_sel[2] = ser_map_q[DMX_RX1_LSB +: DMX_SEL_W];
   assign src_sel[3] = ser_map_q[DMX_RX2_LSB +: DMX_SEL_W];
   assign src_sel[4] = ser_map_q[DMX_TX1_LSB +: DMX_SEL_W];
   assign src_sel[5] = ser_map_q[DMX_TX2_LSB +: DMX_SEL_W];

   // Code validity per source; anything else is left unconnected.
   assign src_ok[0] = (src_sel[0] <= DMX_SEL_PAIR0_LAST) &&
                      (src_sel[0] != DMX_SEL_CASCADE);
   assign src_ok[1] = (src_sel[1] <= DMX_SEL_PAIR1_LAST) &&
                      (src_sel[1] != DMX_SEL_CASCADE);
   assign src_ok[2] = src_sel[2] <= DMX_SEL_LAST_LOW;
   assign src_ok[3] = src_sel[3] <= DMX_SEL_LAST_LOW;
   assign src_ok[4] = src_sel[4] <= DMX_SEL_LAST_LOW;
   assign src_ok[5] = src_sel[5] <= DMX_SEL_LAST_LOW;

   // Request sources; external pins only after synchronisation.
   assign src_req = {serial_tx2_request, serial_tx1_request,
                     serial_rx2_request, serial_rx1_request,
                     req1_sync_q[DMX_SYNC_STAGES-1],
                     req0_sync_q[DMX_SYNC_STAGES-1]};

   // Each source takes its selected channel's acknowledge when routed.
   genvar s;
   generate
      for (s = 0; s < 6; s++) begin : g_src
         assign src_chan[s] = src_sel[s][2:0];
         assign src_ack[s] = src_ok[s] && chan_ack[src_chan[s]];
      end
   endgenerate

   // Each channel's request is the OR of all sources routed to it.
   genvar c;
   generate
      for (c = 0; c < DMX_CHANNELS; c++) begin : g_chan
         logic [5:0] hit;
         for (s = 0; s < 6; s++) begin : g_hit
            assign hit[s] = src_ok[s] && (src_chan[s] == 3'(c)) &&
                            src_req[s];
         end
         assign chan_req[c] = |hit;
      end
   endgenerate

   assign ext_ack_out_0 = src_ack[0];
   assign ext_ack_out_1 = src_ack[1];
   assign serial_rx1_ack = src_ack[2];
   assign serial_rx2_ack = src_ack[3];
   assign serial_tx1_ack = src_ack[4];
   assign serial_tx2_ack = src_ack[5];

   // Two-stage synchronisers for the external request pins.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         req0_sync_q <= '0;
         req1_sync_q <= '0;
      end else begin
         req0_sync_q <= {req0_sync_q[0], ext_req_in_0};
         req1_sync_q <= {req1_sync_q[0], ext_req_in_1};
      end
   end

   // Register decode.
   assign sel_ext_lo = reg_addr == DMX_EXT_MAP_LO_OFS;
   assign sel_ext_hi = reg_addr == DMX_EXT_MAP_HI_OFS;
   assign sel_ser_lo = reg_addr == DMX_SER_MAP_LO_OFS;
   assign sel_ser_hi = reg_addr == DMX_SER_MAP_HI_OFS;
   assign page_wr[0] = reg_wr && (reg_addr == DMX_PAGE0_OFS);
   assign page_wr[1] = reg_wr && (reg_addr == DMX_PAGE1_OFS);
   assign page_wr[2] = reg_wr && (reg_addr == DMX_PAGE2_OFS);
   assign page_wr[3] = reg_wr && (reg_addr == DMX_PAGE3_OFS);
   assign page_wr[4] = reg_wr && (reg_addr == DMX_PAGE5_OFS);

   // Map registers, byte writable.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ext_map_q <= DMX_EXT_MAP_RESET;
         ser_map_q <= DMX_SER_MAP_RESET;
      end else begin
         if (reg_wr && sel_ext_lo) ext_map_q[7:0] <= reg_wdata;
         if (reg_wr && sel_ext_hi) ext_map_q[15:8] <= reg_wdata;
         if (reg_wr && sel_ser_lo) ser_map_q[7:0] <= reg_wdata;
         if (reg_wr && sel_ser_hi) ser_map_q[15:8] <= reg_wdata;
      end
   end

   // Read mux; reserved page bits and unmapped offsets read as zero.
   always_comb begin
      rdata_d = 8'h00;
      case (reg_addr)
         DMX_EXT_MAP_LO_OFS: rdata_d = ext_map_q[7:0];
         DMX_EXT_MAP_HI_OFS: rdata_d = ext_map_q[15:8];
         DMX_SER_MAP_LO_OFS: rdata_d = ser_map_q[7:0];
         DMX_SER_MAP_HI_OFS: rdata_d = ser_map_q[15:8];
         DMX_PAGE0_OFS: rdata_d = {4'h0, page_q[0]};
         DMX_PAGE1_OFS: rdata_d = {4'h0, page_q[1]};
         DMX_PAGE2_OFS: rdata_d = {4'h0, page_q[2]};
         DMX_PAGE3_OFS: rdata_d = {4'h0, page_q[3]};
         DMX_PAGE5_OFS: rdata_d = {4'h0, page_q[4]};
         default: rdata_d = 8'h00;
      endcase
   end

   // Read data register, loaded on a read strobe.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rdata_q <= 8'h00;
      end else if (reg_rd) begin
         rdata_q <= rdata_d;
      end
   end
   assign reg_rdata = rdata_q;

   // Only channels 3 and 5 receive crossing pulses.
   assign page_up = {ch5_page_up, ch3_page_up, 3'b000};
   assign page_down = {ch5_page_down, ch3_page_down, 3'b000};

   // Extended page registers, one per paged channel.
   genvar p;
   generate
      for (p = 0; p < DMX_PAGE_CHANNELS; p++) begin : g_page
         dmx_xpage #(
            .STEP_CAPABLE(p >= 3)
         ) u_page (
            .clk(clk),
            .rst(rst),
            .wr_en(page_wr[p]),
            .wr_data(reg_wdata[DMX_PAGE_W-1:0]),
            .enhanced(extended_mode_enable),
            .step_up(page_up[p]),
            .step_down(page_down[p]),
            .page_q(page_q[p])
         );
         // Full 28-bit address per channel, registered.
         always_ff @(posedge clk or posedge rst) begin
            if (rst) begin
               mem_addr_q[p] <= '0;
            end else begin
               mem_addr_q[p] <= {page_q[p], low_addr[p]};
            end
         end
      end
   endgenerate

   assign mem_addr = mem_addr_q;
   assign ch0_addr_top_bits = page_q[0];
   assign ch1_addr_top_bits = page_q[1];
   assign ch2_addr_top_bits = page_q[2];
   assign ch3_addr_top_bits = page_q[3];
   assign ch5_addr_top_bits = page_q[4];
endmodule
`default_nettype wire

// ### dmx_pkg.sv
// Shared constants for the DMA request map and extended page block.
// Assumes byte-wide register access at the controller's register offsets.
`default_nettype none
package dmx_pkg;
   localparam int unsigned DMX_CHANNELS = 8;
   localparam int unsigned DMX_PAGE_CHANNELS = 5;
   localparam int unsigned DMX_LOW_ADDR_W = 24;
   localparam int unsigned DMX_ADDR_W = 28;
   localparam int unsigned DMX_SYNC_STAGES = 2;
   // Register offsets.
   localparam logic [11:0] DMX_EXT_MAP_LO_OFS = 12'hd82;
   localparam logic [11:0] DMX_EXT_MAP_HI_OFS = 12'hd83;
   localparam logic [11:0] DMX_SER_MAP_LO_OFS = 12'hd84;
   localparam logic [11:0] DMX_SER_MAP_HI_OFS = 12'hd85;
   localparam logic [11:0] DMX_PAGE0_OFS = 12'hd86;
   localparam logic [11:0] DMX_PAGE1_OFS = 12'hd87;
   localparam logic [11:0] DMX_PAGE2_OFS = 12'hd88;
   localparam logic [11:0] DMX_PAGE3_OFS = 12'hd89;
   localparam logic [11:0] DMX_PAGE5_OFS = 12'hd8a;
   // Reset values.
   localparam logic [15:0] DMX_EXT_MAP_RESET = 16'hffff;
   localparam logic [15:0] DMX_SER_MAP_RESET = 16'hffff;
   localparam logic [3:0] DMX_PAGE_RESET = 4'h0;
   // Field positions inside the two map registers.
   localparam int unsigned DMX_PAIR0_LSB = 0;
   localparam int unsigned DMX_PAIR1_LSB = 4;
   localparam int unsigned DMX_RX1_LSB = 0;
   localparam int unsigned DMX_RX2_LSB = 4;
   localparam int unsigned DMX_TX1_LSB = 8;
   localparam int unsigned DMX_TX2_LSB = 12;
   localparam int unsigned DMX_SEL_W = 4;
   // Selector code classes.
   localparam logic [3:0] DMX_SEL_LAST_LOW = 4'h3;
   localparam logic [3:0] DMX_SEL_CASCADE = 4'h4;
   localparam logic [3:0] DMX_SEL_PAIR0_LAST = 4'h6;
   localparam logic [3:0] DMX_SEL_PAIR1_LAST = 4'h7;
   // Page register fields.
   localparam int unsigned DMX_PAGE_W = 4;
endpackage
`default_nettype wire

// ### dmx_xpage.sv
// One extended page register holding address bits 27 to 24 of a channel.
// Assumes step pulses come from the transfer engine on the same clock.
`default_nettype none
module dmx_xpage #(
   parameter bit STEP_CAPABLE = 1'b0
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic wr_en,
   input wire logic [dmx_pkg::DMX_PAGE_W-1:0] wr_data,
   input wire logic enhanced,
   input wire logic step_up,
   input wire logic step_down,
   output logic [dmx_pkg::DMX_PAGE_W-1:0] page_q
);
   import dmx_pkg::*;

   logic [DMX_PAGE_W-1:0] page_d;
   logic step_ok;
   logic up_go;
   logic down_go;

   // Stepping only happens on capable channels in enhanced mode.
   assign step_ok = STEP_CAPABLE && enhanced;
   assign up_go = step_ok && step_up && !step_down;
   assign down_go = step_ok && step_down && !step_up;
   // A hardware step wins over a software write in the same cycle.
   assign page_d = up_go ? page_q + 4'h1 :
                   down_go ? page_q - 4'h1 :
                   wr_en ? wr_data : page_q;

   // Page register with reset to zero.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         page_q <= DMX_PAGE_RESET;
      end else begin
         page_q <= page_d;
      end
   end
endmodule
`default_nettype wire

// ### dmx_peer.sv
// Model of the pins and serial ports that raise DMA requests.
// Assumes the bench sets want, one bit per source, on the block's clock.
`default_nettype none
module dmx_peer (
   input wire logic clk,
   input wire logic rst,
   input wire logic [5:0] want,
   output logic [5:0] req_q
);
   timeunit 1ns;
   timeprecision 1ps;
   // Requests are levels launched just after an edge, as a device does.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) req_q <= 6'h00;
      else req_q <= want;
   end
endmodule
`default_nettype wire

// ### dmx_map_page_sva.sv
// Checker for the request map and extended page block.
// Assumes it is bound to the block and sees only its ports.
`default_nettype none
module dmx_map_page_sva (
   input wire logic clk,
   input wire logic rst,
   input wire logic [11:0] reg_addr,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_rdata,
   input wire logic extended_mode_enable,
   input wire logic ext_ack_out_0,
   input wire logic serial_tx1_ack,
   input wire logic [7:0] chan_req,
   input wire logic [7:0] chan_ack,
   input wire logic ch3_page_up,
   input wire logic ch3_page_down,
   input wire logic ch5_page_up,
   input wire logic ch5_page_down,
   input wire logic [4:0][23:0] low_addr,
   input wire logic [4:0][27:0] mem_addr,
   input wire logic [3:0] ch0_addr_top_bits,
   input wire logic [3:0] ch3_addr_top_bits,
   input wire logic [3:0] ch5_addr_top_bits
);
   timeunit 1ns;
   timeprecision 1ps;
   // All checks share the one clock and its reset.
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   no_ch4_req_a: assert property (chan_req[4] == 1'b0)
      else $error("channel 4 request raised");
   ack_idle_a: assert property (
      chan_ack == 8'h00 |-> !ext_ack_out_0 && !serial_tx1_ack)
      else $error("ack without channel ack");
   ch0_hold_a: assert property (
      !reg_wr |=> $stable(ch0_addr_top_bits))
      else $error("channel 0 page moved");
   normal_hold_a: assert property (
      !reg_wr && !extended_mode_enable |=>
      $stable(ch3_addr_top_bits) && $stable(ch5_addr_top_bits))
      else $error("page moved in normal mode");
   ch3_up_a: assert property (
      extended_mode_enable && ch3_page_up && !ch3_page_down |=>
      ch3_addr_top_bits == $past(ch3_addr_top_bits) + 4'h1)
      else $error("channel 3 page did not step up");
   ch5_down_a: assert property (
      extended_mode_enable && ch5_page_down && !ch5_page_up |=>
      ch5_addr_top_bits == $past(ch5_addr_top_bits) - 4'h1)
      else $error("channel 5 page did not step down");
   addr_join_a: assert property (
      1'b1 |=> mem_addr[3] ==
      {$past(ch3_addr_top_bits), $past(low_addr[3])})
      else $error("channel 3 address not joined");
   page_upper_a: assert property (
      reg_rd && reg_addr == 12'hd8a |=> reg_rdata[7:4] == 4'h0)
      else $error("reserved page bits read nonzero");
   rdata_hold_a: assert property (
      !reg_rd |=> $stable(reg_rdata))
      else $error("read data moved without a read");
   cover property (extended_mode_enable && ch3_page_up);
   cover property (chan_req[7]);
   cover property (serial_tx1_ack);
endmodule
bind dmx_map_page dmx_map_page_sva u_sva (.clk, .rst, .reg_addr, .reg_wr,
   .reg_rd, .reg_rdata, .extended_mode_enable, .ext_ack_out_0,
   .serial_tx1_ack, .chan_req, .chan_ack, .ch3_page_up, .ch3_page_down,
   .ch5_page_up, .ch5_page_down, .low_addr, .mem_addr,
   .ch0_addr_top_bits, .ch3_addr_top_bits, .ch5_addr_top_bits);
`default_nettype wire

// ### testbench.sv
// Self-checking bench for the request map and extended page block.
// Assumes the package, the block, its checker and the peer come first.
`default_nettype none
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin n_errors++; \
$display("BAD t=%0t got=%h exp=%h", $time, g, e); end end
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   import dmx_pkg::*;
   logic clk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, mode = 1'b0;
   logic [11:0] reg_addr = 12'h000;
   logic [7:0] reg_wdata = 8'h00, reg_rdata, chan_req, chan_ack = 8'h00;
   logic [5:0] want = 6'h00, req;
   wire [5:0] ack;
   logic [3:0] up = 4'h0;
   logic [3:0] top [5];
   logic [4:0][23:0] low_addr = '0;
   logic [4:0][27:0] mem_addr;
   logic [15:0] lfsr = 16'h6f79;
   int n_errors = 0, n_checks = 0, cyc = 0;
   dmx_peer u_peer (.clk(clk), .rst(rst), .want(want), .req_q(req));
   dmx_map_page u_dut (.clk(clk), .rst(rst), .reg_addr(reg_addr),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
      .reg_rdata(reg_rdata), .extended_mode_enable(mode),
      .ext_req_in_0(req[0]), .ext_req_in_1(req[1]),
      .ext_ack_out_0(ack[0]), .ext_ack_out_1(ack[1]),
      .serial_tx1_request(req[2]), .serial_tx2_request(req[3]),
      .serial_rx1_request(req[4]), .serial_rx2_request(req[5]),
      .serial_tx1_ack(ack[2]), .serial_tx2_ack(ack[3]),
      .serial_rx1_ack(ack[4]), .serial_rx2_ack(ack[5]),
      .chan_req(chan_req), .chan_ack(chan_ack), .ch3_page_up(up[0]),
      .ch3_page_down(up[1]), .ch5_page_up(up[2]), .ch5_page_down(up[3]),
      .low_addr(low_addr), .mem_addr(mem_addr),
      .ch0_addr_top_bits(top[0]), .ch1_addr_top_bits(top[1]),
      .ch2_addr_top_bits(top[2]), .ch3_addr_top_bits(top[3]),
      .ch5_addr_top_bits(top[4]));
   // Clock and a cycle ceiling that cuts a hang short.
   initial begin
      forever #20 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         n_errors++;
         report_and_stop();
      end
   end
   // Shift register source of repeatable random values.
   function automatic logic [15:0] rnd();
      lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
      return lfsr;
   endfunction
   // Channel a source should reach for a code; zero when unconnected.
   function automatic logic [7:0] exp_map(int s, logic [3:0] c);
      logic ok;
      ok = c <= 4'h3 || (s < 2 && (c == 4'h5 || c == 4'h6)) ||
         (s == 1 && c == 4'h7);
      return ok ? 8'h01 << c : 8'h00;
   endfunction
   // Byte writes and reads, launched just after an edge; an idle edge
   // follows each so a strobe is never dropped and raised in one step.
   task automatic wr(logic [11:0] a, logic [7:0] d);
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(posedge clk);
      #1 reg_wr = 1'b0;
      @(posedge clk);
      #1;
   endtask
   task automatic rd(logic [11:0] a, logic [7:0] e);
      reg_addr = a;
      reg_rd = 1'b1;
      @(posedge clk);
      #1 reg_rd = 1'b0;
      `CHK(reg_rdata, e)
      @(posedge clk);
      #1;
   endtask
   // One step pulse, then both stepping pages are compared.
   task automatic step(logic [3:0] p, logic [3:0] e3, logic [3:0] e5);
      up = p;
      @(posedge clk);
      #1 up = 4'h0;
      `CHK(top[3], e3)
      `CHK(top[4], e5)
      @(posedge clk);
      #1;
   endtask
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   // Main sequence: reset values, routing of every code, pages, stepping.
   initial begin
      logic [11:0] a;
      logic [7:0] d, m;
      logic [15:0] r;
      repeat (16) @(posedge clk);
      #1 rst = 1'b0;
      for (int i = 0; i < 9; i++) begin
         rd(12'hd82 + 12'(i), i < 4 ? 8'hff : 8'h00);
      end
      rd(12'h000, 8'h00);
      `CHK(chan_req, 8'h00)
      $display("END reset values");
      for (int s = 0; s < 6; s++) begin
         a = s < 2 ? 12'hd82 : (s < 4 ? 12'hd85 : 12'hd84);
         for (int c = 0; c < 16; c++) begin
            d = s[0] ? {4'(c), 4'hf} : {4'hf, 4'(c)};
            wr(a, d);
            rd(a, d);
            r = rnd();
            want = 6'h01 << s;
            chan_ack = r[7:0];
            repeat (4) @(posedge clk);
            #1 m = exp_map(s, 4'(c));
            `CHK(chan_req, m)
            `CHK(ack[s], |(m & chan_ack))
            want = 6'h00;
         end
         wr(a, 8'hff);
      end
      $display("END routing");
      for (int i = 0; i < 5; i++) begin
         r = rnd();
         wr(12'hd86 + 12'(i), {4'h0, r[3:0]});
         rd(12'hd86 + 12'(i), {4'h0, r[3:0]});
         `CHK(top[i], r[3:0])
         low_addr[i] = {r, r[7:0]};
         repeat (2) @(posedge clk);
         #1 `CHK(mem_addr[i], {r[3:0], r, r[7:0]})
      end
      $display("END pages");
      wr(12'hd89, 8'h0f);
      wr(12'hd8a, 8'h00);
      step(4'h5, 4'hf, 4'h0);
      mode = 1'b1;
      step(4'h1, 4'h0, 4'h0);
      step(4'h8, 4'h0, 4'hf);
      step(4'h3, 4'h0, 4'hf);
      $display("END stepping");
      report_and_stop();
   end
endmodule
`default_nettype wire
